// file: inc/poc_pkg.sv
// Constants for the probe output conditioning block.
// Assumes a 10 MHz system clock and readings in whole ppm.
// Operation
// - Sample select pin once at power-on; the code also resamples it after every soft reset.
// - Only one output mode active at once.
// - Finish start-up within two seconds.
// - Purge about four minutes, readings unavailable.
// - Analog purge drives both outputs to error.
// - Zero clamp disabled until enabled.
// - Clamp settings survive soft resets.
// - Activation timer starts below activation level.
// - Expired activation timer forces zero output.
// - Pending activation passes readings unchanged.
// - Deactivation timer starts above deactivation level.
// - Qualified rise restores normal output.
// - Deactivation also cancels pending activation.
// - Levels and delays settable by host.
// - Release jumps straight to measured value.
// - Digital mode uses serial RTU link.
package poc_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned STARTUP_MS = 2000;
  localparam int unsigned PURGE_S = 240;
  localparam int unsigned WARMUP_S = 510;
  localparam logic [31:0] STARTUP_CYC = 32'(64'(STARTUP_MS) * 64'(CLK_HZ) / 64'd1000);
  localparam logic [31:0] PURGE_CYC = 32'(64'(PURGE_S) * 64'(CLK_HZ));
  localparam logic [31:0] SEC_CYC = 32'(CLK_HZ);
  localparam logic [15:0] ACT_LEVEL_RST = 16'h0003;
  localparam logic [15:0] DEACT_LEVEL_RST = 16'h000A;
  localparam logic [15:0] ACT_DELAY_RST = 16'h0708;
  localparam logic [15:0] DEACT_DELAY_RST = 16'h000A;
  localparam logic [15:0] ERR_UA_RST = 16'h0E10;
  localparam logic [15:0] ZERO_PPM = 16'h0000;
  localparam logic SEL_GROUNDED = 1'b0;
  typedef enum logic [1:0] {ST_SAMPLE, ST_BOOT, ST_PURGE, ST_RUN} poc_state_t;
endpackage : poc_pkg

// file: design/poc_sec_timer.sv
// Seconds timer: counts whole seconds while run is high.
// Assumes run drops for at least one cycle to restart it.
`timescale 1ns/1ps
`default_nettype none
module poc_sec_timer #(
  parameter logic [31:0] CYC_PER_SEC = 32'd10000000
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [15:0] limit,
  output logic done
);
  localparam logic [31:0] PRE_MAX = CYC_PER_SEC - 32'd1;
  logic [31:0] pre_q;
  logic [15:0] sec_q;

  assign done = run && (sec_q >= limit);

  // Prescaler and seconds count
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pre_q <= 32'h0000_0000;
      sec_q <= 16'h0000;
    end
    else if (!run)
    begin
      pre_q <= 32'h0000_0000;
      sec_q <= 16'h0000;
    end
    else if (!done)
    begin
      if (pre_q >= PRE_MAX)
      begin
        pre_q <= 32'h0000_0000;
        sec_q <= sec_q + 16'h0001;
      end
      else
      begin
        pre_q <= pre_q + 32'h0000_0001;
      end
    end
  end
endmodule : poc_sec_timer
`default_nettype wire

// file: design/poc_conditioning.sv
// Output conditioning: mode select, start-up purge and zero clamp.
// Assumes readings arrive with a one-cycle valid strobe, all inputs synchronous.
`timescale 1ns/1ps
`default_nettype none
module poc_conditioning #(
  parameter logic [31:0] BOOT_CYC = poc_pkg::STARTUP_CYC,
  parameter logic [31:0] PURGE_CYC = poc_pkg::PURGE_CYC,
  parameter logic [31:0] SEC_CYC = poc_pkg::SEC_CYC
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic soft_rst,
  input wire logic sel_pin,
  input wire logic meas_valid,
  input wire logic [15:0] meas_ppm,
  input wire logic [15:0] ain1_ua,
  input wire logic [15:0] ain2_ua,
  input wire logic cfg_we,
  input wire logic cfg_clamp_en,
  input wire logic [15:0] cfg_act_level,
  input wire logic [15:0] cfg_deact_level,
  input wire logic [15:0] cfg_act_delay,
  input wire logic [15:0] cfg_deact_delay,
  input wire logic [15:0] cfg_err_ua,
  input wire logic ser_tx,
  input wire logic ser_de,
  input wire logic rs485_rx,
  output logic mode_analog_q,
  output logic outputs_en_q,
  output logic purge_active_q,
  output logic meas_avail_q,
  output logic clamp_active_q,
  output logic clamp_pending_q,
  output logic [15:0] conc_out_q,
  output logic ao_en_q,
  output logic [15:0] ao1_ua_q,
  output logic [15:0] ao2_ua_q,
  output logic rs485_tx_q,
  output logic rs485_de_q,
  output logic ser_rx_q,
  output logic clamp_en_q,
  output logic [15:0] act_level_q,
  output logic [15:0] deact_level_q,
  output logic [15:0] act_delay_q,
  output logic [15:0] deact_delay_q,
  output logic [15:0] err_ua_q
);
  poc_pkg::poc_state_t state_q;
  logic [31:0] phase_cnt_q;
  logic [15:0] meas_q;
  logic [15:0] meas_d;
  logic below_act;
  logic above_deact;
  logic run_clamp;
  logic act_run;
  logic deact_run;
  logic act_done;
  logic deact_done;
  logic clamp_d;
  logic pend_d;
  logic up;

  assign up = (state_q == poc_pkg::ST_PURGE) || (state_q == poc_pkg::ST_RUN);

  // Configuration, kept across soft resets
  // Settings survive soft reset
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clamp_en_q <= 1'b0;
      act_level_q <= poc_pkg::ACT_LEVEL_RST;
      deact_level_q <= poc_pkg::DEACT_LEVEL_RST;
      act_delay_q <= poc_pkg::ACT_DELAY_RST;
      deact_delay_q <= poc_pkg::DEACT_DELAY_RST;
      err_ua_q <= poc_pkg::ERR_UA_RST;
    end
    else if (cfg_we)
    begin
      clamp_en_q <= cfg_clamp_en;
      act_level_q <= cfg_act_level;
      deact_level_q <= cfg_deact_level;
      act_delay_q <= cfg_act_delay;
      deact_delay_q <= cfg_deact_delay;
      err_ua_q <= cfg_err_ua;
    end
  end

  // Start-up sequence
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= poc_pkg::ST_SAMPLE;
      phase_cnt_q <= 32'h0000_0000;
      mode_analog_q <= 1'b0;
    end
    else if (soft_rst)
    begin
      state_q <= poc_pkg::ST_SAMPLE;
      phase_cnt_q <= 32'h0000_0000;
    end
    else
    begin
      case (state_q)
        poc_pkg::ST_SAMPLE:
        begin
          mode_analog_q <= (sel_pin == poc_pkg::SEL_GROUNDED);
          state_q <= poc_pkg::ST_BOOT;
          phase_cnt_q <= 32'h0000_0000;
        end
        poc_pkg::ST_BOOT:
        begin
          if (phase_cnt_q >= BOOT_CYC - 32'd2)
          begin
            state_q <= poc_pkg::ST_PURGE;
            phase_cnt_q <= 32'h0000_0000;
          end
          else
          begin
            phase_cnt_q <= phase_cnt_q + 32'h0000_0001;
          end
        end
        poc_pkg::ST_PURGE:
        begin
          if (phase_cnt_q >= PURGE_CYC - 32'd1)
          begin
            state_q <= poc_pkg::ST_RUN;
            phase_cnt_q <= 32'h0000_0000;
          end
          else
          begin
            phase_cnt_q <= phase_cnt_q + 32'h0000_0001;
          end
        end
        default:
        begin
          phase_cnt_q <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Status flags
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      outputs_en_q <= 1'b0;
      purge_active_q <= 1'b0;
      meas_avail_q <= 1'b0;
    end
    else
    begin
      outputs_en_q <= up && !soft_rst;
      purge_active_q <= (state_q == poc_pkg::ST_PURGE) && !soft_rst;
      meas_avail_q <= (state_q == poc_pkg::ST_RUN) && !soft_rst;
    end
  end

  // Latest reading
  assign meas_d = meas_valid ? meas_ppm : meas_q;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meas_q <= poc_pkg::ZERO_PPM;
    end
    else
    begin
      meas_q <= meas_d;
    end
  end

  // Clamp conditions
  assign run_clamp = clamp_en_q && (state_q == poc_pkg::ST_RUN) && !soft_rst;
  assign below_act = meas_q < act_level_q;
  assign above_deact = meas_q > deact_level_q;
  assign act_run = run_clamp && clamp_pending_q;
  assign deact_run = run_clamp && (clamp_pending_q || clamp_active_q) && above_deact;

  poc_sec_timer #(
    .CYC_PER_SEC(SEC_CYC)
  ) u_act_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(act_run),
    .limit(act_delay_q),
    .done(act_done)
  );

  poc_sec_timer #(
    .CYC_PER_SEC(SEC_CYC)
  ) u_deact_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .run(deact_run),
    .limit(deact_delay_q),
    .done(deact_done)
  );

  // Clamp next state
  always_comb
  begin
    clamp_d = clamp_active_q;
    pend_d = clamp_pending_q;
    if (!run_clamp)
    begin
      clamp_d = 1'b0;
      pend_d = 1'b0;
    end
    else if (deact_done)
    begin
      clamp_d = 1'b0;
      pend_d = 1'b0;
    end
    else if (act_done)
    begin
      clamp_d = 1'b1;
      pend_d = 1'b0;
    end
    else if (!clamp_active_q && !clamp_pending_q && below_act)
    begin
      pend_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      clamp_active_q <= 1'b0;
      clamp_pending_q <= 1'b0;
      conc_out_q <= poc_pkg::ZERO_PPM;
    end
    else
    begin
      clamp_active_q <= clamp_d;
      clamp_pending_q <= pend_d;
      conc_out_q <= clamp_d ? poc_pkg::ZERO_PPM : meas_d;
    end
  end

  // Analog drivers
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ao_en_q <= 1'b0;
      ao1_ua_q <= 16'h0000;
      ao2_ua_q <= 16'h0000;
    end
    else
    begin
      ao_en_q <= mode_analog_q && up && !soft_rst;
      if (!(mode_analog_q && up))
      begin
        ao1_ua_q <= 16'h0000;
        ao2_ua_q <= 16'h0000;
      end
      else if (state_q == poc_pkg::ST_PURGE)
      begin
        ao1_ua_q <= err_ua_q;
        ao2_ua_q <= err_ua_q;
      end
      else
      begin
        ao1_ua_q <= ain1_ua;
        ao2_ua_q <= ain2_ua;
      end
    end
  end

  // Serial line drivers
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rs485_tx_q <= 1'b1;
      rs485_de_q <= 1'b0;
      ser_rx_q <= 1'b1;
    end
    else
    begin
      // Serial link only in digital mode
      rs485_de_q <= !mode_analog_q && up && !soft_rst && ser_de;
      rs485_tx_q <= (!mode_analog_q && up) ? ser_tx : 1'b1;
      ser_rx_q <= (!mode_analog_q && up) ? rs485_rx : 1'b1;
    end
  end

  // Checks
  // Modes exclusive
  AST_MODE_EXCL: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(ao_en_q && rs485_de_q))
    else $error("Analog and serial drivers on together");

  AST_SEL_ONCE: assert property (@(posedge sys_clk) disable iff (!rstn)
    $changed(mode_analog_q) |-> $past(state_q == poc_pkg::ST_SAMPLE))
    else $error("Output mode changed outside sampling");

  AST_BOOT_BOUND: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_q == poc_pkg::ST_BOOT) |-> (phase_cnt_q < BOOT_CYC))
    else $error("Start-up exceeded its limit");

  AST_PURGE_UNAVAIL: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_q == poc_pkg::ST_PURGE && !soft_rst) |=> !meas_avail_q && purge_active_q)
    else $error("Reading available during purge");

  AST_PURGE_ERR: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_q == poc_pkg::ST_PURGE && mode_analog_q && !soft_rst)
    |=> (ao1_ua_q == $past(err_ua_q)) && (ao2_ua_q == $past(err_ua_q)))
    else $error("Analog outputs not at error level in purge");

  AST_CLAMP_OFF: assert property (@(posedge sys_clk) disable iff (!rstn)
    !clamp_en_q |=> !clamp_active_q && !clamp_pending_q)
    else $error("Clamp active while disabled");

  AST_CLAMP_ZERO: assert property (@(posedge sys_clk) disable iff (!rstn)
    clamp_active_q |-> (conc_out_q == poc_pkg::ZERO_PPM))
    else $error("Clamped output not zero");

  AST_ACT_FIRE: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(clamp_active_q) |-> $past(act_done) && $past(clamp_pending_q))
    else $error("Clamp set without activation expiry");

  AST_PASS_PENDING: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clamp_pending_q && $past(clamp_pending_q)) |-> (conc_out_q == meas_q))
    else $error("Reading altered while activation pending");

  AST_DEACT_RELEASE: assert property (@(posedge sys_clk) disable iff (!rstn)
    ($fell(clamp_active_q) && $past(run_clamp)) |-> $past(deact_done))
    else $error("Clamp released without deactivation delay");

  AST_DEACT_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
    (clamp_active_q && run_clamp && !above_deact) |=> clamp_active_q || !$past(run_clamp))
    else $error("Clamp released at or below deactivation level");

  AST_RELEASE_STEP: assert property (@(posedge sys_clk) disable iff (!rstn)
    $fell(clamp_active_q) |-> (conc_out_q == meas_q))
    else $error("Output not at measured value after release");
endmodule : poc_conditioning
`default_nettype wire

// file: sim/poc_host.sv
// Host model on the far side: drives the receive line, tracks warm-up.
// Assumes a biased line that idles high while the host is in reset.
`timescale 1ns/1ps
`default_nettype none
module poc_host #(
  parameter int WARM = 40
) (
  input wire logic sys_clk,
  input wire logic rstn,
  output logic rx_line,
  output logic warm_q
);
  int seed = 1644;
  int cnt_q;
  always @(posedge sys_clk or negedge rstn)
    if (!rstn)
      rx_line <= 1'b1;
    else
      rx_line <= 1'($random(seed));
  always @(posedge sys_clk or negedge rstn)
    if (!rstn)
      cnt_q <= 0;
    else if (cnt_q < WARM)
      cnt_q <= cnt_q + 1;
  assign warm_q = (cnt_q == WARM);
endmodule : poc_host
`default_nettype wire

// file: sim/poc_conditioning_bench.sv
// Bench for output conditioning: boots, purge, zero clamp and modes.
// Assumes shortened cycle counts and the host model on the line.
`timescale 1ns/1ps
`default_nettype none
module poc_conditioning_bench;
  localparam logic [31:0] BOOT = 32'h8, PURGE = 32'h14, SEC = 32'h4;
  logic sys_clk = 1'b0, rstn = 1'b0, soft_rst = 1'b0, sel_pin = 1'b0, cfg_we = 1'b0;
  logic meas_valid = 1'b0, cfg_clamp_en = 1'b0, ser_tx = 1'b1, ser_de = 1'b0, vq = 1'b0;
  logic [15:0] meas_ppm = 16'h0, ain1_ua = 16'h0, ain2_ua = 16'h0, cfg_err_ua = 16'h0;
  logic [15:0] cfg_act_level = 16'h0, cfg_deact_level = 16'h0;
  logic [15:0] cfg_act_delay = 16'h0, cfg_deact_delay = 16'h0;
  wire logic rs485_rx, warm;
  logic mode_analog_q, outputs_en_q, purge_active_q, meas_avail_q, clamp_en_q;
  logic clamp_active_q, clamp_pending_q, ao_en_q, rs485_tx_q, rs485_de_q, ser_rx_q;
  logic [15:0] conc_out_q, ao1_ua_q, ao2_ua_q, act_level_q, deact_level_q;
  logic [15:0] act_delay_q, deact_delay_q, err_ua_q;
  logic [15:0] exp_q[$];
  int seed = 1644, fail_count = 0, total_checks = 0, n;

  poc_conditioning #(.BOOT_CYC(BOOT), .PURGE_CYC(PURGE), .SEC_CYC(SEC))
    poc_conditioning_i (.sys_clk(sys_clk), .rstn(rstn), .soft_rst(soft_rst),
    .sel_pin(sel_pin), .meas_valid(meas_valid), .meas_ppm(meas_ppm), .ain1_ua(ain1_ua),
    .ain2_ua(ain2_ua), .cfg_we(cfg_we), .cfg_clamp_en(cfg_clamp_en),
    .cfg_act_level(cfg_act_level), .cfg_deact_level(cfg_deact_level),
    .cfg_act_delay(cfg_act_delay), .cfg_deact_delay(cfg_deact_delay),
    .cfg_err_ua(cfg_err_ua), .ser_tx(ser_tx), .ser_de(ser_de), .rs485_rx(rs485_rx),
    .mode_analog_q(mode_analog_q), .outputs_en_q(outputs_en_q),
    .purge_active_q(purge_active_q), .meas_avail_q(meas_avail_q),
    .clamp_active_q(clamp_active_q), .clamp_pending_q(clamp_pending_q),
    .conc_out_q(conc_out_q), .ao_en_q(ao_en_q), .ao1_ua_q(ao1_ua_q), .ao2_ua_q(ao2_ua_q),
    .rs485_tx_q(rs485_tx_q), .rs485_de_q(rs485_de_q), .ser_rx_q(ser_rx_q),
    .clamp_en_q(clamp_en_q), .act_level_q(act_level_q), .deact_level_q(deact_level_q),
    .act_delay_q(act_delay_q), .deact_delay_q(deact_delay_q), .err_ua_q(err_ua_q));
  poc_host poc_host_i (.sys_clk(sys_clk), .rstn(rstn), .rx_line(rs485_rx),
    .warm_q(warm));

  always #50 sys_clk = ~sys_clk;

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic cfgchk(logic en, logic [15:0] al, dl, ad, dd, er);
    chk("cen", en, clamp_en_q);
    chk("cal", al, act_level_q);
    chk("cdl", dl, deact_level_q);
    chk("cad", ad, act_delay_q);
    chk("cdd", dd, deact_delay_q);
    chk("cer", er, err_ua_q);
  endtask : cfgchk

  task automatic cfg(logic en, logic [15:0] al, dl, ad, dd, er);
    @(posedge sys_clk);
    cfg_we <= 1'b1;
    cfg_clamp_en <= en;
    cfg_act_level <= al;
    cfg_deact_level <= dl;
    cfg_act_delay <= ad;
    cfg_deact_delay <= dd;
    cfg_err_ua <= er;
    @(posedge sys_clk);
    cfg_we <= 1'b0;
    @(negedge sys_clk);
    cfgchk(en, al, dl, ad, dd, er);
  endtask : cfg

  task automatic meas(logic [15:0] v, logic [15:0] e);
    @(posedge sys_clk);
    meas_valid <= 1'b1;
    meas_ppm <= v;
    exp_q.push_back(e);
    @(posedge sys_clk);
    meas_valid <= 1'b0;
    meas_ppm <= 16'($random(seed));
  endtask : meas

  task automatic boot(logic sel, logic hard, logic [15:0] er);
    int c;
    @(posedge sys_clk);
    sel_pin <= sel;
    rstn <= !hard;
    soft_rst <= !hard;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    soft_rst <= 1'b0;
    @(posedge sys_clk);
    sel_pin <= !sel;
    for (n = 0; n < 20 && outputs_en_q !== 1'b1; n++) @(negedge sys_clk);
    chk("upt", 1'b1, n <= BOOT + 3);
    c = 0;
    while (purge_active_q === 1'b1 && c < 99)
    begin
      chk("avl", 1'b0, meas_avail_q);
      chk("ao1", sel ? 16'h0 : er, ao1_ua_q);
      chk("ao2", sel ? 16'h0 : er, ao2_ua_q);
      c++;
      @(negedge sys_clk);
    end
    chk("prg", 16'(PURGE), 16'(c));
    chk("pga", 1'b0, purge_active_q);
    chk("avl", 1'b1, meas_avail_q);
    chk("mod", !sel, mode_analog_q);
    if (hard)
      cfgchk(1'b0, poc_pkg::ACT_LEVEL_RST, poc_pkg::DEACT_LEVEL_RST, poc_pkg::ACT_DELAY_RST,
        poc_pkg::DEACT_DELAY_RST, poc_pkg::ERR_UA_RST);
  endtask : boot

  task automatic io(logic sel);
    logic [15:0] a, b;
    logic t, d, r;
    repeat (6)
    begin
      @(posedge sys_clk);
      a = 16'($random(seed));
      b = 16'($random(seed));
      {t, d} = 2'($random(seed));
      ain1_ua <= a;
      ain2_ua <= b;
      ser_tx <= t;
      ser_de <= d;
      @(posedge sys_clk);
      r = rs485_rx;
      @(negedge sys_clk);
      chk("ao1", sel ? 16'h0 : a, ao1_ua_q);
      chk("ao2", sel ? 16'h0 : b, ao2_ua_q);
      chk("aen", !sel, ao_en_q);
      chk("de", sel & d, rs485_de_q);
      if (sel)
      begin
        chk("tx", t, rs485_tx_q);
        chk("rx", r, ser_rx_q);
      end
    end
  endtask : io

  always @(posedge sys_clk) vq <= meas_valid;
  always @(negedge sys_clk)
    if (vq)
      chk("cnc", exp_q.pop_front(), conc_out_q);

  initial
  begin
    boot(1'b0, 1'b1, poc_pkg::ERR_UA_RST);
    io(1'b0);
    wait (warm === 1'b1);
    meas(16'h0, 16'h0);
    repeat (4) @(negedge sys_clk);
    chk("pnd", 1'b0, clamp_pending_q);
    cfg(1'b1, 16'h3, 16'hA, 16'h4, 16'h2, 16'hBB8);
    meas(16'h2, 16'h2);
    repeat (2) @(negedge sys_clk);
    chk("pnd", 1'b1, clamp_pending_q);
    meas(16'h5, 16'h5);
    for (n = 0; n < 60 && clamp_active_q !== 1'b1; n++) @(negedge sys_clk);
    chk("clp", 1'b1, clamp_active_q);
    chk("adl", 1'b1, n > 6);
    meas(16'h1, 16'h0);
    meas(16'hB, 16'h0);
    repeat (4) @(negedge sys_clk);
    meas(16'hA, 16'h0);
    repeat (16) @(negedge sys_clk);
    chk("clp", 1'b1, clamp_active_q);
    meas(16'hB, 16'h0);
    for (n = 0; n < 40 && clamp_active_q !== 1'b0; n++) @(negedge sys_clk);
    chk("clp", 1'b0, clamp_active_q);
    chk("cnc", 16'hB, conc_out_q);
    chk("ddl", 1'b1, n > 5);
    meas(16'h2, 16'h2);
    meas(16'hC, 16'hC);
    for (n = 0; n < 40 && clamp_pending_q !== 1'b0; n++) @(negedge sys_clk);
    chk("clp", 1'b0, clamp_active_q);
    repeat (20) @(negedge sys_clk);
    chk("pnd", 1'b0, clamp_pending_q);
    chk("clp", 1'b0, clamp_active_q);
    boot(1'b0, 1'b0, 16'hBB8);
    cfgchk(1'b1, 16'h3, 16'hA, 16'h4, 16'h2, 16'hBB8);
    boot(1'b1, 1'b1, 16'hBB8);
    io(1'b1);
    wrap_up();
  end

  initial
  begin
    repeat (3000) @(posedge sys_clk);
    fail_count++;
    wrap_up();
  end
endmodule : poc_conditioning_bench
`default_nettype wire
